// ===== src/nfcd_top.sv
// Flash command decoder with APB register access
`include "nfcd_regs.svh"
module nfcd_top #(
    parameter int BLOCKS   = 16,
    parameter int BLK_BITS = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             op_start,
    output logic [2:0]       op_kind,
    output logic [31:0]      op_addr,
    output logic [15:0]      op_data,
    output logic             op_abort_n
);
    localparam int BW = $clog2(BLOCKS);
    nfcd_cmd_if cmd ();
    nfcd_pkg::nfcd_state_t  state;
    nfcd_pkg::nfcd_state_t  next_state;
    nfcd_pkg::nfcd_rdmode_t rdmode;
    nfcd_pkg::nfcd_op_t     cur_op;
    logic [7:0]  status;
    logic [15:0] cfg;
    logic [15:0] word_data;
    logic [9:0]  buf_left;
    logic        done_pulse;
    logic        clr_err;
    logic        seq_err;
    logic        lock_en, unlock_en, down_en;
    logic [1:0]  lock_state;
    logic [31:0] lock_addr;
    logic        wr_acc;
    logic        rd_acc;
    logic        is_cmd;
    logic [7:0]  code;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign op_abort_n = presetn;

    // A command write carries code and address; word data comes from the WDATA register
    always_comb begin
        cmd.wr   = wr_acc && paddr == `NFCD_ADDR_CMD;
        cmd.code = pwdata[7:0];
        cmd.addr = {16'h0000, pwdata[31:16]};
        cmd.data = word_data;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_data <= 16'h0000;
        end else if (wr_acc && paddr == `NFCD_ADDR_WDATA) begin
            word_data <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_addr <= 32'h0000_0000;
        end else if (wr_acc && paddr == `NFCD_ADDR_LOCK) begin
            lock_addr <= pwdata;
        end
    end

    assign done_pulse = wr_acc && paddr == `NFCD_ADDR_CTRL && pwdata[`NFCD_CTRL_DONE_BIT];
    assign is_cmd = cmd.wr;
    assign code = cmd.code;

    // Next state of the command sequencer
    always_comb begin
        next_state = state;
        seq_err = 1'b0;
        lock_en = 1'b0;
        unlock_en = 1'b0;
        down_en = 1'b0;
        if (is_cmd) begin
            unique case (state)
                nfcd_pkg::NFCD_IDLE: begin
                    if (code == `NFCD_CMD_WORDPROG) next_state = nfcd_pkg::NFCD_WPROG_S;
                    else if (code == `NFCD_CMD_BUFPROG) next_state = nfcd_pkg::NFCD_BUF_CNT;
                    else if (code == `NFCD_CMD_FACTORY) next_state = nfcd_pkg::NFCD_FACT_S;
                    else if (code == `NFCD_CMD_ERASE) next_state = nfcd_pkg::NFCD_ERASE_S;
                    else if (code == `NFCD_CMD_PROTECT) next_state = nfcd_pkg::NFCD_PROT_S;
                    else if (code == `NFCD_CMD_REGPROG) next_state = nfcd_pkg::NFCD_REGP_S;
                end
                nfcd_pkg::NFCD_WPROG_S: next_state = nfcd_pkg::NFCD_BUSY;
                nfcd_pkg::NFCD_REGP_S:  next_state = nfcd_pkg::NFCD_BUSY;
                nfcd_pkg::NFCD_BUF_CNT: next_state = nfcd_pkg::NFCD_BUF_LOAD;
                nfcd_pkg::NFCD_BUF_LOAD: begin
                    if (buf_left == 10'd1) next_state = nfcd_pkg::NFCD_BUF_CONF;
                end
                nfcd_pkg::NFCD_BUF_CONF: begin
                    if (code == `NFCD_CMD_CONFIRM) next_state = nfcd_pkg::NFCD_BUSY;
                    else begin
                        seq_err = 1'b1;
                        next_state = nfcd_pkg::NFCD_IDLE;
                    end
                end
                nfcd_pkg::NFCD_FACT_S: begin
                    if (code == `NFCD_CMD_CONFIRM) next_state = nfcd_pkg::NFCD_FACTORY;
                    else begin
                        seq_err = 1'b1;
                        next_state = nfcd_pkg::NFCD_IDLE;
                    end
                end
                nfcd_pkg::NFCD_FACTORY: next_state = nfcd_pkg::NFCD_FACTORY;
                nfcd_pkg::NFCD_ERASE_S: begin
                    if (code == `NFCD_CMD_CONFIRM) next_state = nfcd_pkg::NFCD_BUSY;
                    else begin
                        seq_err = 1'b1;
                        next_state = nfcd_pkg::NFCD_IDLE;
                    end
                end
                nfcd_pkg::NFCD_PROT_S: begin
                    next_state = nfcd_pkg::NFCD_IDLE;
                    if (code == `NFCD_CMD_LOCK) lock_en = 1'b1;
                    else if (code == `NFCD_CMD_CONFIRM) unlock_en = 1'b1;
                    else if (code == `NFCD_CMD_LOCKDOWN) down_en = 1'b1;
                    else if (code != `NFCD_CMD_SETCFG) seq_err = 1'b1;
                end
                nfcd_pkg::NFCD_BUSY: begin
                    if (code == `NFCD_CMD_SUSPEND) next_state = nfcd_pkg::NFCD_SUSP;
                end
                nfcd_pkg::NFCD_SUSP: begin
                    if (code == `NFCD_CMD_CONFIRM) next_state = nfcd_pkg::NFCD_BUSY;
                end
                default: next_state = nfcd_pkg::NFCD_IDLE;
            endcase
        end else if (done_pulse && state == nfcd_pkg::NFCD_BUSY) begin
            next_state = nfcd_pkg::NFCD_IDLE;
        end
    end

    // Suspend holds until resume or reset, no control signal leaves it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= nfcd_pkg::NFCD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Buffered-program word countdown; count above capacity is clamped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_left <= 10'd0;
        end else if (is_cmd && state == nfcd_pkg::NFCD_BUF_CNT) begin
            if (word_data >= 16'(`NFCD_BUF_WORDS)) buf_left <= 10'(`NFCD_BUF_WORDS);
            else buf_left <= 10'(word_data + 16'd1);
        end else if (is_cmd && state == nfcd_pkg::NFCD_BUF_LOAD) begin
            buf_left <= buf_left - 10'd1;
        end
    end

    // Operation launch toward the array engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_start <= 1'b0;
            op_kind <= 3'h0;
            op_addr <= 32'h0000_0000;
            op_data <= 16'h0000;
            cur_op <= nfcd_pkg::NFCD_OP_NONE;
        end else begin
            op_start <= 1'b0;
            if (is_cmd) begin
                unique case (state)
                    nfcd_pkg::NFCD_WPROG_S: begin
                        op_start <= 1'b1;
                        op_kind <= nfcd_pkg::NFCD_OP_WORD;
                        cur_op <= nfcd_pkg::NFCD_OP_WORD;
                        op_addr <= cmd.addr;
                        op_data <= cmd.data;
                    end
                    nfcd_pkg::NFCD_REGP_S: begin
                        op_start <= 1'b1;
                        op_kind <= nfcd_pkg::NFCD_OP_REG;
                        cur_op <= nfcd_pkg::NFCD_OP_REG;
                        op_addr <= cmd.addr;
                        op_data <= cmd.data;
                    end
                    nfcd_pkg::NFCD_BUF_CONF: begin
                        if (code == `NFCD_CMD_CONFIRM) begin
                            op_start <= 1'b1;
                            op_kind <= nfcd_pkg::NFCD_OP_BUF;
                            cur_op <= nfcd_pkg::NFCD_OP_BUF;
                        end
                    end
                    nfcd_pkg::NFCD_FACT_S: begin
                        if (code == `NFCD_CMD_CONFIRM) begin
                            op_start <= 1'b1;
                            op_kind <= nfcd_pkg::NFCD_OP_FACT;
                            cur_op <= nfcd_pkg::NFCD_OP_FACT;
                            op_addr <= cmd.addr;
                            op_data <= cmd.data;
                        end
                    end
                    nfcd_pkg::NFCD_ERASE_S: begin
                        if (code == `NFCD_CMD_CONFIRM) begin
                            op_start <= 1'b1;
                            op_kind <= nfcd_pkg::NFCD_OP_ERASE;
                            cur_op <= nfcd_pkg::NFCD_OP_ERASE;
                            op_addr <= cmd.addr;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Status bits; a hardware set wins over a clear in the same cycle
    assign clr_err = (is_cmd && state == nfcd_pkg::NFCD_IDLE && code == `NFCD_CMD_CLRSTAT)
                   || (wr_acc && paddr == `NFCD_ADDR_CTRL && pwdata[`NFCD_CTRL_CLR_BIT]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= `NFCD_SR_RESET;
        end else begin
            // Factory mode is a running program, so ready stays low there
            status[`NFCD_SR_READY] <= !(next_state == nfcd_pkg::NFCD_BUSY
                                        || next_state == nfcd_pkg::NFCD_FACTORY);
            status[`NFCD_SR_PSUS] <= next_state == nfcd_pkg::NFCD_SUSP && cur_op != nfcd_pkg::NFCD_OP_ERASE;
            status[`NFCD_SR_ESUS] <= next_state == nfcd_pkg::NFCD_SUSP && cur_op == nfcd_pkg::NFCD_OP_ERASE;
            if (seq_err) begin
                status[`NFCD_SR_PERR] <= 1'b1;
                status[`NFCD_SR_EERR] <= 1'b1;
            end else if (clr_err) begin
                status[`NFCD_SR_PERR] <= 1'b0;
                status[`NFCD_SR_EERR] <= 1'b0;
            end
        end
    end

    // Read-mode select; status reads refresh on every access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdmode <= nfcd_pkg::NFCD_RD_ARRAY;
        end else if (is_cmd) begin
            if (state == nfcd_pkg::NFCD_PROT_S && code == `NFCD_CMD_SETCFG) rdmode <= nfcd_pkg::NFCD_RD_ARRAY;
            else if (next_state != nfcd_pkg::NFCD_IDLE || seq_err) rdmode <= nfcd_pkg::NFCD_RD_STATUS;
            else if (state == nfcd_pkg::NFCD_IDLE && code == `NFCD_CMD_RDSTAT) rdmode <= nfcd_pkg::NFCD_RD_STATUS;
            else if (state == nfcd_pkg::NFCD_IDLE && code == `NFCD_CMD_RDID) rdmode <= nfcd_pkg::NFCD_RD_ID;
            else if (state == nfcd_pkg::NFCD_IDLE && code == `NFCD_CMD_RDARRAY) rdmode <= nfcd_pkg::NFCD_RD_ARRAY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 16'h0000;
        end else if (is_cmd && state == nfcd_pkg::NFCD_PROT_S && code == `NFCD_CMD_SETCFG) begin
            cfg <= cmd.addr[BLK_BITS-1:BLK_BITS-16];
        end
    end

    nfcd_lock_table #(.BLOCKS(BLOCKS)) u_lock (
        .pclk      (pclk),
        .presetn   (presetn),
        .lock_en   (lock_en),
        .unlock_en (unlock_en),
        .down_en   (down_en),
        .blk       (lock_en || unlock_en || down_en ? cmd.addr[BW+BLK_BITS-1:BLK_BITS] : lock_addr[BW-1:0]),
        .state     (lock_state)
    );

    // Registered read data; status data updates each read access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `NFCD_ADDR_STATUS: prdata <= {24'h000000, status};
                `NFCD_ADDR_OPINFO: prdata <= {24'h000000, 1'b0, cur_op, state};
                `NFCD_ADDR_CONFIG: prdata <= {16'h0000, cfg};
                `NFCD_ADDR_LOCK:   prdata <= {30'h0, lock_state};
                `NFCD_ADDR_DATA:   prdata <= {30'h0, rdmode};
                `NFCD_ADDR_WDATA:  prdata <= {16'h0000, word_data};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    sequence s_prog_cmd;
        is_cmd && state == nfcd_pkg::NFCD_WPROG_S;
    endsequence
    sequence s_erase_confirm;
        is_cmd && state == nfcd_pkg::NFCD_ERASE_S && code == `NFCD_CMD_CONFIRM;
    endsequence
    a_word_launch: assert property (@(posedge pclk) disable iff (!presetn)
        s_prog_cmd |=> op_start && op_kind == 3'(nfcd_pkg::NFCD_OP_WORD) && !status[`NFCD_SR_READY])
        else $error("word program not launched");
    a_busy_filter: assert property (@(posedge pclk) disable iff (!presetn)
        state == nfcd_pkg::NFCD_BUSY && is_cmd && code != `NFCD_CMD_SUSPEND |=> state == nfcd_pkg::NFCD_BUSY)
        else $error("busy accepted foreign command");
    a_erase_seq_err: assert property (@(posedge pclk) disable iff (!presetn)
        is_cmd && state == nfcd_pkg::NFCD_ERASE_S && code != `NFCD_CMD_CONFIRM
        |=> status[`NFCD_SR_PERR] && status[`NFCD_SR_EERR] && rdmode == nfcd_pkg::NFCD_RD_STATUS && !op_start)
        else $error("erase sequence error not flagged");
    a_erase_launch: assert property (@(posedge pclk) disable iff (!presetn)
        s_erase_confirm |=> op_start && op_kind == 3'(nfcd_pkg::NFCD_OP_ERASE) && !status[`NFCD_SR_READY])
        else $error("erase not launched");

    // Setup code 0x60 is shared, so the set code is not an error here
    a_prot_seq_err: assert property (@(posedge pclk) disable iff (!presetn)
        is_cmd && state == nfcd_pkg::NFCD_PROT_S
        && !(code inside {`NFCD_CMD_LOCK, `NFCD_CMD_CONFIRM, `NFCD_CMD_LOCKDOWN, `NFCD_CMD_SETCFG})
        |=> status[`NFCD_SR_PERR] && status[`NFCD_SR_EERR]) else $error("protection sequence error not flagged");
    a_buf_launch: assert property (@(posedge pclk) disable iff (!presetn)
        is_cmd && state == nfcd_pkg::NFCD_BUF_CONF && code == `NFCD_CMD_CONFIRM
        |=> op_start && op_kind == 3'(nfcd_pkg::NFCD_OP_BUF)) else $error("buffered program not launched");
    a_regp_launch: assert property (@(posedge pclk) disable iff (!presetn)
        is_cmd && state == nfcd_pkg::NFCD_REGP_S
        |=> op_start && op_kind == 3'(nfcd_pkg::NFCD_OP_REG) && op_data == $past(cmd.data))
        else $error("register program not launched");

    a_factory_launch: assert property (@(posedge pclk) disable iff (!presetn)
        is_cmd && state == nfcd_pkg::NFCD_FACT_S && code == `NFCD_CMD_CONFIRM
        |=> op_start && op_kind == 3'(nfcd_pkg::NFCD_OP_FACT) && op_addr == $past(cmd.addr))
        else $error("factory mode not launched");
    a_factory_busy: assert property (@(posedge pclk) disable iff (!presetn)
        state == nfcd_pkg::NFCD_FACTORY |-> !status[`NFCD_SR_READY])
        else $error("ready set in factory mode");
    a_factory_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state == nfcd_pkg::NFCD_FACTORY |=> state == nfcd_pkg::NFCD_FACTORY)
        else $error("factory mode left");
    a_suspend_flags: assert property (@(posedge pclk) disable iff (!presetn)
        state == nfcd_pkg::NFCD_BUSY && is_cmd && code == `NFCD_CMD_SUSPEND
        |=> status[`NFCD_SR_READY] && (status[`NFCD_SR_PSUS] != status[`NFCD_SR_ESUS]))
        else $error("suspend status wrong");
    a_suspend_stays: assert property (@(posedge pclk) disable iff (!presetn)
        state == nfcd_pkg::NFCD_SUSP && !(is_cmd && code == `NFCD_CMD_CONFIRM) |=> state == nfcd_pkg::NFCD_SUSP)
        else $error("suspend left without resume");
    a_resume_busy: assert property (@(posedge pclk) disable iff (!presetn)
        state == nfcd_pkg::NFCD_SUSP && is_cmd && code == `NFCD_CMD_CONFIRM
        |=> state == nfcd_pkg::NFCD_BUSY ##1 !status[`NFCD_SR_READY] || state != nfcd_pkg::NFCD_BUSY)
        else $error("resume failed");
    a_cfg_array: assert property (@(posedge pclk) disable iff (!presetn)
        is_cmd && state == nfcd_pkg::NFCD_PROT_S && code == `NFCD_CMD_SETCFG
        |=> rdmode == nfcd_pkg::NFCD_RD_ARRAY && cfg == $past(cmd.addr[15:0]) && !status[`NFCD_SR_PERR])
        else $error("configuration write wrong");
endmodule : nfcd_top

// ===== src/nfcd_regs.svh
// Register offsets, field positions, reset values, command codes and buffer size for the flash command decoder
`ifndef NFCD_REGS_SVH
`define NFCD_REGS_SVH
`define NFCD_ADDR_CTRL     12'h000
`define NFCD_ADDR_CMD      12'h004
`define NFCD_ADDR_WDATA    12'h008
`define NFCD_ADDR_STATUS   12'h00c
`define NFCD_ADDR_OPINFO   12'h010
`define NFCD_ADDR_CONFIG   12'h014
`define NFCD_ADDR_LOCK     12'h018
`define NFCD_ADDR_DATA     12'h01c
`define NFCD_CTRL_DONE_BIT 0
`define NFCD_CTRL_CLR_BIT  1
`define NFCD_SR_PSUS       2
`define NFCD_SR_PERR       4
`define NFCD_SR_EERR       5
`define NFCD_SR_ESUS       6
`define NFCD_SR_READY      7
`define NFCD_SR_RESET      8'h80
`define NFCD_CMD_RDARRAY   8'hff
`define NFCD_CMD_RDSTAT    8'h70
`define NFCD_CMD_RDID      8'h90
`define NFCD_CMD_CLRSTAT   8'h50
`define NFCD_CMD_WORDPROG  8'h40
`define NFCD_CMD_BUFPROG   8'he8
`define NFCD_CMD_CONFIRM   8'hd0
`define NFCD_CMD_FACTORY   8'h80
`define NFCD_CMD_ERASE     8'h20
`define NFCD_CMD_SUSPEND   8'hb0
`define NFCD_CMD_PROTECT   8'h60
`define NFCD_CMD_LOCK      8'h01
`define NFCD_CMD_LOCKDOWN  8'h2f
`define NFCD_CMD_REGPROG   8'hc0
`define NFCD_CMD_SETCFG    8'h03
`define NFCD_BUF_WORDS     512
`endif

// ===== src/nfcd_pkg.sv
// Types shared by the flash command decoder
package nfcd_pkg;
    typedef enum logic [3:0] {
        NFCD_IDLE     = 4'h0,
        NFCD_WPROG_S  = 4'h1,
        NFCD_BUF_CNT  = 4'h3,
        NFCD_BUF_LOAD = 4'h2,
        NFCD_BUF_CONF = 4'h6,
        NFCD_FACT_S   = 4'h7,
        NFCD_FACTORY  = 4'h5,
        NFCD_ERASE_S  = 4'h4,
        NFCD_PROT_S   = 4'hc,
        NFCD_REGP_S   = 4'hd,
        NFCD_BUSY     = 4'hf,
        NFCD_SUSP     = 4'he
    } nfcd_state_t;
    typedef enum logic [1:0] {
        NFCD_RD_ARRAY  = 2'h0,
        NFCD_RD_STATUS = 2'h1,
        NFCD_RD_ID     = 2'h2
    } nfcd_rdmode_t;
    typedef enum logic [2:0] {
        NFCD_OP_NONE  = 3'h0,
        NFCD_OP_WORD  = 3'h1,
        NFCD_OP_BUF   = 3'h2,
        NFCD_OP_ERASE = 3'h3,
        NFCD_OP_REG   = 3'h4,
        NFCD_OP_FACT  = 3'h5
    } nfcd_op_t;
endpackage : nfcd_pkg

// ===== src/nfcd_cmd_if.sv
// Command write strobe carried from the bus slave to the decoder
interface nfcd_cmd_if;
    logic        wr;
    logic [7:0]  code;
    logic [31:0] addr;
    logic [15:0] data;
    modport src (output wr, code, addr, data);
    modport dst (input  wr, code, addr, data);
endinterface : nfcd_cmd_if

// ===== src/nfcd_lock_table.sv
// Per-block lock and lock-down bits
`include "nfcd_regs.svh"
module nfcd_lock_table #(
    parameter int BLOCKS = 16
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      lock_en,
    input  wire logic                      unlock_en,
    input  wire logic                      down_en,
    input  wire logic [$clog2(BLOCKS)-1:0] blk,
    output logic      [1:0]                state
);
    logic [BLOCKS-1:0] locked;
    logic [BLOCKS-1:0] down;
    // Blocks power up locked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked <= '1;
        end else if (lock_en || down_en) begin
            locked[blk] <= 1'b1;
        end else if (unlock_en && !down[blk]) begin
            locked[blk] <= 1'b0;
        end
    end
    // Lock-down is cleared only by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            down <= '0;
        end else if (down_en) begin
            down[blk] <= 1'b1;
        end
    end
    assign state = {down[blk], locked[blk]};
    a_unlock_downed: assert property (@(posedge pclk) disable iff (!presetn)
        unlock_en && down[blk] |=> locked[$past(blk)]) else $error("locked-down block unlocked");
endmodule : nfcd_lock_table

// ===== dv/nfcd_host_model.sv
// APB host model issuing register transfers to the decoder
module nfcd_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // Request held until pready seen high; no wait count assumed
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // nfcd_host_model

// ===== dv/tb.sv
// Self-checking bench for the flash command decoder
`include "nfcd_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, op_start, op_abort_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, op_addr, q;
    logic [2:0]  op_kind;
    logic [15:0] op_data, wd, ad;
    logic [7:0]  pc [4] = '{8'h01, 8'hd0, 8'h2f, 8'hd0};
    logic [1:0]  pe [4] = '{2'b01, 2'b00, 2'b11, 2'b11};
    int          bad_count = 0, total_checks = 0, starts = 0, cyc = 0;
    nfcd_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                          .pwdata(pwdata), .prdata(prdata), .pready(pready));
    nfcd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                  .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data),
                  .op_abort_n(op_abort_n));
    always #4 pclk = ~pclk;
    always @(posedge pclk) if (op_start === 1'b1) starts <= starts + 1;
    // Ceiling well above the fewer than a hundred transfers below
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    function automatic logic [31:0] srv(logic r, logic es, logic ee, logic pe_, logic ps);
        return {24'h0, r, es, ee, pe_, 1'b0, ps, 2'b00};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [15:0] a);
        host.xfer(1'b1, `NFCD_ADDR_CMD, {a, 8'h00, c}, q);
    endtask
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        chk(n, e, q & m);
    endtask
    task automatic sr(input logic [31:0] e);
        rd("status", `NFCD_ADDR_STATUS, 32'hff, e);
    endtask
    task automatic st(input logic [3:0] e);
        rd("state", `NFCD_ADDR_OPINFO, 32'hf, {28'h0, e});
    endtask
    task automatic md(input logic [1:0] e);
        rd("mode", `NFCD_ADDR_DATA, 32'h3, {30'h0, e});
    endtask
    task automatic lk(input logic [1:0] e);
        host.xfer(1'b1, `NFCD_ADDR_LOCK, 32'h0, q);
        rd("lock", `NFCD_ADDR_LOCK, 32'h3, {30'h0, e});
    endtask
    task automatic done();
        host.xfer(1'b1, `NFCD_ADDR_CTRL, 32'h1, q);
    endtask
    task automatic launched(input logic [2:0] k, input int n);
        // Launch is registered and counted one edge later; let both settle
        repeat (2) @(posedge pclk);
        chk("kind", {29'h0, k}, {29'h0, op_kind});
        chk("starts", n, starts);
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hab238b88));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        sr(srv(1, 0, 0, 0, 0));
        md(2'h0);
        wd = 16'($urandom);
        ad = 16'($urandom);
        host.xfer(1'b1, `NFCD_ADDR_WDATA, {16'h0, wd}, q);
        cmd(8'h40, ad);
        cmd(8'h00, ad);
        sr(srv(0, 0, 0, 0, 0));
        launched(3'h1, 1);
        chk("data", {16'h0, wd}, {16'h0, op_data});
        chk("addr", {16'h0, ad}, op_addr);
        md(2'h1);
        cmd(8'h20, 16'h0);
        st(nfcd_pkg::NFCD_BUSY);
        chk("slverr", 32'h0, {31'h0, pslverr});
        cmd(8'hb0, 16'h0);
        sr(srv(1, 0, 0, 0, 1));
        cmd(8'h70, 16'h0);
        st(nfcd_pkg::NFCD_SUSP);
        cmd(8'hd0, 16'h0);
        st(nfcd_pkg::NFCD_BUSY);
        done();
        sr(srv(1, 0, 0, 0, 0));
        cmd(8'hff, 16'h0);
        md(2'h0);
        cmd(8'h20, 16'h0);
        cmd(8'h70, 16'h0);
        sr(srv(1, 0, 1, 1, 0));
        cmd(8'h50, 16'h0);
        cmd(8'h20, ad);
        cmd(8'hd0, ad);
        launched(3'h3, 2);
        cmd(8'hb0, 16'h0);
        sr(srv(1, 1, 0, 0, 0));
        cmd(8'hd0, 16'h0);
        done();
        lk(2'b01);
        for (int i = 0; i < 4; i++) begin
            cmd(8'h60, 16'h0);
            cmd(pc[i], 16'h0);
            lk(pe[i]);
        end
        cmd(8'h60, 16'h0);
        cmd(8'h55, 16'h0);
        sr(srv(1, 0, 1, 1, 0));
        cmd(8'h50, 16'h0);
        cmd(8'h60, ad);
        cmd(8'h03, ad);
        rd("config", `NFCD_ADDR_CONFIG, 32'hffff, {16'h0, ad});
        sr(srv(1, 0, 0, 0, 0));
        md(2'h0);
        cmd(8'hc0, ad);
        cmd(8'h00, ad);
        st(nfcd_pkg::NFCD_BUSY);
        launched(3'h4, 3);
        done();
        // Three words, count written as N-1
        host.xfer(1'b1, `NFCD_ADDR_WDATA, 32'h2, q);
        cmd(8'he8, ad);
        cmd(8'h00, ad);
        for (int i = 0; i < 3; i++) begin
            host.xfer(1'b1, `NFCD_ADDR_WDATA, {16'h0, 16'($urandom)}, q);
            cmd(8'h00, ad);
        end
        chk("starts", 3, starts);
        cmd(8'hd0, ad);
        st(nfcd_pkg::NFCD_BUSY);
        launched(3'h2, 4);
        done();
        cmd(8'h80, ad);
        cmd(8'hd0, ad);
        sr(srv(0, 0, 0, 0, 0));
        launched(3'h5, 5);
        chk("addr", {16'h0, ad}, op_addr);
        cmd(8'hff, 16'h0);
        st(nfcd_pkg::NFCD_FACTORY);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("abort", 32'h0, {31'h0, op_abort_n});
        presetn <= 1'b1;
        st(nfcd_pkg::NFCD_IDLE);
        sr(srv(1, 0, 0, 0, 0));
        stop_test();
    end
endmodule // tb
